// ==== rtl/ufc_pkg.sv ====
// Shared constants and types of the unified four-way cache
package ufc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int WAYS     = 4;
  localparam int WAY_W    = 2;
  localparam int WORDS    = 4;
  localparam int WORD_W   = 2;
  localparam int DATA_W   = 32;
  localparam int TAG_W    = 22;
  localparam int TAG_LSB  = 10;
  localparam int SHADOW_W = 3;
  localparam int IDX_LSB  = 4;
  localparam int WSEL_LSB = 2;
  localparam int LRU_W    = 6;
  localparam logic [LRU_W-1:0] LRU_RST = 6'h00;

  // Pairwise recency bits: a one means the first way of the pair is older
  localparam int L01 = 5;
  localparam int L02 = 4;
  localparam int L03 = 3;
  localparam int L12 = 2;
  localparam int L13 = 1;
  localparam int L23 = 0;

  // ----------------------------------------------------------------
  // Address regions
  // ----------------------------------------------------------------
  localparam int REG_LSB = 29;
  localparam int REG_W   = 3;
  localparam logic [REG_W-1:0] REG_HIGH = 3'h4;
  localparam logic [REG_W-1:0] REG_UNC  = 3'h5;
  localparam logic [REG_W-1:0] REG_IO   = 3'h7;

  // ----------------------------------------------------------------
  // Register map and control fields
  // ----------------------------------------------------------------
  localparam int AVS_AW = 2;
  localparam logic [AVS_AW-1:0] CTRL_IDX = 2'h0;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam int CE_BIT = 0;
  localparam int WT_BIT = 1;
  localparam int CB_BIT = 2;
  localparam int CF_BIT = 3;

  typedef enum logic [1:0] {S_IDLE, S_WBACK, S_FILL, S_PASS} ufc_state_t;
endpackage : ufc_pkg

// ==== rtl/ufc_cache.sv ====
// Unified four-way set-associative cache with control register slave
// Notes on behaviour
// - Unified instruction and data cache of four ways, tag and data parts.
// - 64 or 256 entries per way; each line is four 32-bit words.
// - Each entry has a valid flag; one means line contents are good.
// - Each entry has a dirty flag, set by writes in write-back mode.
// - Tag is address bits 31..10, compared on every lookup.
// - Upper three tag bits are always stored and compared as zero.
// - Reset clears all valid and dirty flags; tags and data stay random.
// - Reset clears every set's replacement bits to all zero.
// - Six replacement bits per set pick the least recently used way.
// - Patterns 000000,000100,010100,100000,110000,110100 replace way 3.
// - Patterns 000001,000011,001011,100001,101001,101011 replace way 2.
// - Patterns 000110,000111,001111,010110,011110,011111 replace way 1.
// - Patterns 111000,111001,111011,111100,111110,111111 replace way 0.
// - Policy bit 1 for low and 0xC region: 0 write-back, 1 through.
// - Copy-back bit 2 for 0x8 region: 0 write-through, 1 write-back.
// - Regions at 0xA0000000 and 0xE0000000 are never cached.
// - Writing one to flush bit 3 clears valid, dirty, LRU; reads zero.
// - Flush discards dirty lines without writing them back.
// - Enable bit 0 turns caching on; it resets to zero.
// - Control bits 31..4 read zero; software writes zero there.
// - Set index is address bits 9..4 or 11..4; four ways compared.
// - Hit only when tag matches and that way is valid.
// - Read hit returns cached data and makes the hit way newest.
// - Completed fill sets valid, sets dirty only for a write miss, makes the way newest.
`timescale 1ns/1ps
module ufc_cache #(
  parameter int ENTRIES = 64
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        clkEn,
  input  wire logic [ufc_pkg::AVS_AW-1:0]  avsAddress,
  input  wire logic                        avsRead,
  input  wire logic                        avsWrite,
  input  wire logic [ufc_pkg::DATA_W-1:0]  avsWriteData,
  output logic      [ufc_pkg::DATA_W-1:0]  avsReadData,
  output logic                             avsWaitrequest,
  input  wire logic                        cpuReq,
  input  wire logic                        cpuWrite,
  input  wire logic [ufc_pkg::DATA_W-1:0]  cpuAddr,
  input  wire logic [ufc_pkg::DATA_W-1:0]  cpuWdata,
  output logic      [ufc_pkg::DATA_W-1:0]  cpuRdata,
  output logic                             cpuReady,
  output logic                             memReq,
  output logic                             memWrite,
  output logic      [ufc_pkg::DATA_W-1:0]  memAddr,
  output logic      [ufc_pkg::DATA_W-1:0]  memWdata,
  input  wire logic [ufc_pkg::DATA_W-1:0]  memRdata,
  input  wire logic                        memAck
);
  localparam int IDX_W = $clog2(ENTRIES);
  localparam int TW = ufc_pkg::TAG_W;
  localparam int LW = ufc_pkg::LRU_W;
  localparam int DW = ufc_pkg::DATA_W;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Shadow bits are forced low so aliases share one line
  function automatic logic [TW-1:0] tagOf(input logic [DW-1:0] a);
    tagOf = {{ufc_pkg::SHADOW_W{1'b0}},
             a[ufc_pkg::TAG_LSB +: TW-ufc_pkg::SHADOW_W]};
  endfunction : tagOf

  function automatic logic [IDX_W-1:0] idxOf(input logic [DW-1:0] a);
    idxOf = a[ufc_pkg::IDX_LSB +: IDX_W];
  endfunction : idxOf

  function automatic logic cacheable(input logic [DW-1:0] a);
    logic [ufc_pkg::REG_W-1:0] r;
    r = a[ufc_pkg::REG_LSB +: ufc_pkg::REG_W];
    cacheable = (r != ufc_pkg::REG_UNC) && (r != ufc_pkg::REG_IO);
  endfunction : cacheable

  function automatic logic writeBack(input logic [DW-1:0] a,
                                     input logic [ufc_pkg::CTRL_W-1:0] c);
    if (a[ufc_pkg::REG_LSB +: ufc_pkg::REG_W] == ufc_pkg::REG_HIGH) begin
      writeBack = c[ufc_pkg::CB_BIT];
    end else begin
      writeBack = !c[ufc_pkg::WT_BIT];
    end
  endfunction : writeBack

  function automatic logic [ufc_pkg::WAY_W-1:0] lruVictim(input logic [LW-1:0] l);
    if (!l[ufc_pkg::L03] && !l[ufc_pkg::L13] && !l[ufc_pkg::L23]) begin
      lruVictim = 2'h3;
    end else if (!l[ufc_pkg::L02] && !l[ufc_pkg::L12] && l[ufc_pkg::L23]) begin
      lruVictim = 2'h2;
    end else if (!l[ufc_pkg::L01] && l[ufc_pkg::L12] && l[ufc_pkg::L13]) begin
      lruVictim = 2'h1;
    end else begin
      lruVictim = 2'h0;
    end
  endfunction : lruVictim

  // Makes way w newer than the other three in every pair it belongs to
  function automatic logic [LW-1:0] lruTouch(input logic [LW-1:0] l,
                                             input logic [ufc_pkg::WAY_W-1:0] w);
    lruTouch = l;
    case (w)
      2'h0: begin
        lruTouch[ufc_pkg::L01] = 1'b0;
        lruTouch[ufc_pkg::L02] = 1'b0;
        lruTouch[ufc_pkg::L03] = 1'b0;
      end
      2'h1: begin
        lruTouch[ufc_pkg::L01] = 1'b1;
        lruTouch[ufc_pkg::L12] = 1'b0;
        lruTouch[ufc_pkg::L13] = 1'b0;
      end
      2'h2: begin
        lruTouch[ufc_pkg::L02] = 1'b1;
        lruTouch[ufc_pkg::L12] = 1'b1;
        lruTouch[ufc_pkg::L23] = 1'b0;
      end
      default: begin
        lruTouch[ufc_pkg::L03] = 1'b1;
        lruTouch[ufc_pkg::L13] = 1'b1;
        lruTouch[ufc_pkg::L23] = 1'b1;
      end
    endcase
  endfunction : lruTouch

  function automatic logic [DW-1:0] lineAddr(input logic [TW-1:0] t,
                                             input logic [IDX_W-1:0] i,
                                             input logic [ufc_pkg::WORD_W-1:0] b);
    lineAddr = '0;
    lineAddr[ufc_pkg::TAG_LSB +: TW] = t;
    lineAddr[ufc_pkg::IDX_LSB +: IDX_W] = i;
    lineAddr[ufc_pkg::WSEL_LSB +: ufc_pkg::WORD_W] = b;
  endfunction : lineAddr

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic       rstSn;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSn = rstSync_r[1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [TW-1:0]            tagArr_r   [ufc_pkg::WAYS][ENTRIES];
  logic [DW-1:0]            dataArr_r  [ufc_pkg::WAYS][ENTRIES][ufc_pkg::WORDS];
  logic [ENTRIES-1:0]       validArr_r [ufc_pkg::WAYS];
  logic [ENTRIES-1:0]       dirtyArr_r [ufc_pkg::WAYS];
  logic [LW-1:0]            lruArr_r   [ENTRIES];
  logic [ufc_pkg::CTRL_W-1:0] ctrl_r;
  ufc_pkg::ufc_state_t      state_r;
  logic [ufc_pkg::WORD_W-1:0] beat_r;
  logic [ufc_pkg::WAY_W-1:0]  vicWay_r;
  logic [DW-1:0]            reqAddr_r;
  logic [DW-1:0]            reqWdata_r;
  logic                     reqWe_r;
  logic                     rdPend_r;

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]          idx;
  logic [IDX_W-1:0]          reqIdx;
  logic [ufc_pkg::WORD_W-1:0] wordSel;
  logic [ufc_pkg::WORD_W-1:0] reqWord;
  logic [ufc_pkg::WAYS-1:0]  hitVec;
  logic [ufc_pkg::WAY_W-1:0] hitWay;
  logic [ufc_pkg::WAY_W-1:0] victim;
  logic                      hit;
  logic                      cached;
  logic                      wbMode;
  logic                      start;
  logic                      hitRd;
  logic                      hitWr;
  logic                      fillAck;
  logic                      fillDone;
  logic                      ctrlSel;
  logic                      flushGo;
  logic                      lastBeat;

  assign idx     = idxOf(cpuAddr);
  assign reqIdx  = idxOf(reqAddr_r);
  assign wordSel = cpuAddr[ufc_pkg::WSEL_LSB +: ufc_pkg::WORD_W];
  assign reqWord = reqAddr_r[ufc_pkg::WSEL_LSB +: ufc_pkg::WORD_W];

  always_comb begin
    hitWay = '0;
    for (int w = 0; w < ufc_pkg::WAYS; w++) begin
      hitVec[w] = validArr_r[w][idx] && (tagArr_r[w][idx] == tagOf(cpuAddr));
      if (hitVec[w]) begin
        hitWay = ufc_pkg::WAY_W'(w);
      end
    end
  end

  assign hit      = |hitVec;
  assign victim   = lruVictim(lruArr_r[idx]);
  assign cached   = ctrl_r[ufc_pkg::CE_BIT] && cacheable(cpuAddr);
  assign wbMode   = writeBack(cpuAddr, ctrl_r);
  assign lastBeat = (beat_r == {ufc_pkg::WORD_W{1'b1}});
  // Flush waits for an idle engine so a fill never lands after it
  assign ctrlSel  = (avsAddress == ufc_pkg::CTRL_IDX);
  assign flushGo  = clkEn && avsWrite && ctrlSel && avsWriteData[ufc_pkg::CF_BIT]
                    && (state_r == ufc_pkg::S_IDLE);
  assign start    = (state_r == ufc_pkg::S_IDLE) && cpuReq && !cpuReady && !flushGo;
  assign hitRd    = start && cached && hit && !cpuWrite;
  assign hitWr    = start && cached && hit && cpuWrite;
  assign fillAck  = (state_r == ufc_pkg::S_FILL) && memAck;
  assign fillDone = fillAck && lastBeat;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Reads cost one wait state so read data comes from a flop
  assign avsWaitrequest = !clkEn || (avsRead && !rdPend_r)
                          || (avsWrite && ctrlSel && avsWriteData[ufc_pkg::CF_BIT]
                              && (state_r != ufc_pkg::S_IDLE));

  always_ff @(posedge sys_clk or negedge rstSn) begin
    if (!rstSn) begin
      ctrl_r <= ufc_pkg::CTRL_RST;
    end else if (clkEn && avsWrite && ctrlSel && !avsWaitrequest) begin
      ctrl_r <= avsWriteData[ufc_pkg::CTRL_W-1:0];
      ctrl_r[ufc_pkg::CF_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSn) begin
    if (!rstSn) begin
      rdPend_r    <= 1'b0;
      avsReadData <= '0;
    end else if (clkEn) begin
      rdPend_r <= avsRead && !rdPend_r;
      if (avsRead && !rdPend_r) begin
        avsReadData <= ctrlSel ? {{(DW-ufc_pkg::CTRL_W){1'b0}}, ctrl_r} : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and replacement state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSn) begin
    if (!rstSn) begin
      for (int w = 0; w < ufc_pkg::WAYS; w++) begin
        validArr_r[w] <= '0;
        dirtyArr_r[w] <= '0;
      end
      for (int e = 0; e < ENTRIES; e++) begin
        lruArr_r[e] <= ufc_pkg::LRU_RST;
      end
    end else if (clkEn) begin
      if (flushGo) begin
        // Dirty lines are dropped on purpose: no write-back traffic
        for (int w = 0; w < ufc_pkg::WAYS; w++) begin
          validArr_r[w] <= '0;
          dirtyArr_r[w] <= '0;
        end
        for (int e = 0; e < ENTRIES; e++) begin
          lruArr_r[e] <= ufc_pkg::LRU_RST;
        end
      end else begin
        if (hitRd || hitWr) begin
          lruArr_r[idx] <= lruTouch(lruArr_r[idx], hitWay);
        end
        if (hitWr && wbMode) begin
          dirtyArr_r[hitWay][idx] <= 1'b1;
        end
        if (fillDone) begin
          validArr_r[vicWay_r][reqIdx] <= 1'b1;
          dirtyArr_r[vicWay_r][reqIdx] <= reqWe_r;
          lruArr_r[reqIdx] <= lruTouch(lruArr_r[reqIdx], vicWay_r);
        end
      end
    end
  end

  // Tags and line data carry no reset
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      if (hitWr) begin
        dataArr_r[hitWay][idx][wordSel] <= cpuWdata;
      end
      if (fillAck) begin
        dataArr_r[vicWay_r][reqIdx][beat_r] <=
          (reqWe_r && beat_r == reqWord) ? reqWdata_r : memRdata;
      end
      if (fillDone) begin
        tagArr_r[vicWay_r][reqIdx] <= tagOf(reqAddr_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Miss engine and external bus
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSn) begin
    if (!rstSn) begin
      state_r    <= ufc_pkg::S_IDLE;
      beat_r     <= '0;
      vicWay_r   <= '0;
      reqAddr_r  <= '0;
      reqWdata_r <= '0;
      reqWe_r    <= 1'b0;
      memReq     <= 1'b0;
      memWrite   <= 1'b0;
      memAddr    <= '0;
      memWdata   <= '0;
    end else if (clkEn) begin
      case (state_r)
        ufc_pkg::S_IDLE: begin
          if (start) begin
            reqAddr_r  <= cpuAddr;
            reqWdata_r <= cpuWdata;
            reqWe_r    <= cpuWrite;
            beat_r     <= '0;
            vicWay_r   <= victim;
            if (!cached || (cpuWrite && (hit ? !wbMode : !wbMode))) begin
              state_r  <= ufc_pkg::S_PASS;
              memReq   <= 1'b1;
              memWrite <= cpuWrite;
              memAddr  <= cpuAddr;
              memWdata <= cpuWdata;
            end else if (!hit) begin
              memReq <= 1'b1;
              if (validArr_r[victim][idx] && dirtyArr_r[victim][idx]) begin
                state_r  <= ufc_pkg::S_WBACK;
                memWrite <= 1'b1;
                memAddr  <= lineAddr(tagArr_r[victim][idx], idx, '0);
                memWdata <= dataArr_r[victim][idx][0];
              end else begin
                state_r  <= ufc_pkg::S_FILL;
                memWrite <= 1'b0;
                memAddr  <= lineAddr(tagOf(cpuAddr), idx, '0);
              end
            end
          end
        end
        ufc_pkg::S_WBACK: begin
          if (memAck) begin
            beat_r <= beat_r + 1'b1;
            if (lastBeat) begin
              state_r  <= ufc_pkg::S_FILL;
              memWrite <= 1'b0;
              memAddr  <= lineAddr(tagOf(reqAddr_r), reqIdx, '0);
            end else begin
              memAddr  <= lineAddr(tagArr_r[vicWay_r][reqIdx], reqIdx, beat_r + 1'b1);
              memWdata <= dataArr_r[vicWay_r][reqIdx][beat_r + 1'b1];
            end
          end
        end
        ufc_pkg::S_FILL: begin
          if (memAck) begin
            beat_r  <= beat_r + 1'b1;
            memAddr <= lineAddr(tagOf(reqAddr_r), reqIdx, beat_r + 1'b1);
            if (lastBeat) begin
              state_r <= ufc_pkg::S_IDLE;
              memReq  <= 1'b0;
            end
          end
        end
        ufc_pkg::S_PASS: begin
          if (memAck) begin
            state_r  <= ufc_pkg::S_IDLE;
            memReq   <= 1'b0;
            memWrite <= 1'b0;
          end
        end
        default: begin
          state_r <= ufc_pkg::S_IDLE;
          memReq  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer to the core
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstSn) begin
    if (!rstSn) begin
      cpuReady <= 1'b0;
      cpuRdata <= '0;
    end else if (clkEn) begin
      cpuReady <= 1'b0;
      if (hitRd) begin
        cpuRdata <= dataArr_r[hitWay][idx][wordSel];
        cpuReady <= 1'b1;
      end
      if (hitWr && wbMode) begin
        cpuReady <= 1'b1;
      end
      if (fillAck && beat_r == reqWord && !reqWe_r) begin
        cpuRdata <= memRdata;
      end
      if (fillDone) begin
        cpuReady <= 1'b1;
      end
      if (state_r == ufc_pkg::S_PASS && memAck) begin
        if (!reqWe_r) begin
          cpuRdata <= memRdata;
        end
        cpuReady <= 1'b1;
      end
    end
  end
endmodule : ufc_cache

// ==== verif/ufc_mem_model.sv ====
// Behavioural external memory on the cache's word bus
`timescale 1ns/1ps
module ufc_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] memRdata,
  output logic             memAck
);
  logic [31:0] store [logic [31:0]];
  logic [31:0] key;
  integer      seed = 32'h2557;
  int          cnt = 0;
  // Shadow bits alias one physical word
  assign key = {3'h0, memAddr[28:0]};
  // Latency 0..3 cycles; the data line toggles between beats so a stale word never passes
  always @(posedge sys_clk) begin
    if (memReq === 1'b1 && !memAck && cnt == 0) begin
      memAck   <= 1'b1;
      memRdata <= store.exists(key) ? store[key] : key ^ 32'h5A5A0000;
      if (memWrite === 1'b1) store[key] = memWdata;
      cnt = $random(seed) & 3;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq === 1'b1 && !memAck && cnt > 0) cnt = cnt - 1;
    end
  end
endmodule : ufc_mem_model

// ==== verif/ufc_cache_checker.sv ====
// Port-level assertions for the unified four-way cache
`timescale 1ns/1ps
module ufc_cache_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [1:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitrequest,
  input wire logic [31:0] cpuAddr,
  input wire logic        cpuReady,
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [31:0] memAddr,
  input wire logic        memAck
);
  logic [2:0] ctlR;
  logic       xferSeen;
  logic       wrAcc;
  logic       memUnc;
  logic       cpuUnc;
  logic       fillBeat;
  assign wrAcc  = avsWrite && !avsWaitrequest && avsAddress == ufc_pkg::CTRL_IDX;
  assign memUnc = memAddr[31:29] == ufc_pkg::REG_UNC || memAddr[31:29] == ufc_pkg::REG_IO;
  assign cpuUnc = cpuAddr[31:29] == ufc_pkg::REG_UNC || cpuAddr[31:29] == ufc_pkg::REG_IO;
  assign fillBeat = memReq && memAck && !memWrite && ctlR[0] && !memUnc;
  // Mirror of the control bits and of bus traffic seen since the last completion
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctlR     <= 3'h0;
      xferSeen <= 1'b0;
    end else begin
      if (wrAcc) ctlR <= avsWriteData[2:0];
      if (cpuReady) xferSeen <= 1'b0;
      else if (memReq && memAck) xferSeen <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_CTRL_READ: assert property (
    avsRead && !avsWaitrequest && avsAddress == ufc_pkg::CTRL_IDX
    |-> avsReadData == {29'h0, ctlR}) else $error("control readback wrong");
  AST_UNMAP_ZERO: assert property (
    avsRead && !avsWaitrequest && avsAddress != ufc_pkg::CTRL_IDX |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  AST_UNC_SINGLE: assert property (
    memReq && memAck && memUnc |=> !memReq) else $error("uncached access became a burst");
  AST_OFF_SINGLE: assert property (
    memReq && memAck && !ctlR[0] |=> !memReq) else $error("burst while cache off");
  AST_UNC_REACH: assert property (
    cpuReady && cpuUnc |-> xferSeen) else $error("uncached access served without memory");
  AST_OFF_REACH: assert property (
    cpuReady && !ctlR[0] |-> xferSeen) else $error("access served from cache while off");
  AST_FILL_BASE: assert property (
    $rose(memReq) && !memWrite && ctlR[0] && !memUnc |-> memAddr[3:0] == 4'h0)
    else $error("line fill not from line base");
  AST_FILL_STEP: assert property (
    fillBeat && memAddr[3:0] != 4'hC |=> memReq && memAddr == $past(memAddr) + 32'h4)
    else $error("fill beats out of order");
  AST_FILL_END: assert property (
    fillBeat && memAddr[3:0] == 4'hC |=> !memReq ##[0:1] cpuReady)
    else $error("fill did not end after four words");
  AST_FLUSH_NOWB: assert property (
    wrAcc && avsWriteData[ufc_pkg::CF_BIT] |=> !memReq) else $error("flush started traffic");
endmodule : ufc_cache_checker
bind ufc_cache ufc_cache_checker u_ufc_cache_checker (
  .sys_clk(sys_clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
  .avsWaitrequest(avsWaitrequest), .cpuAddr(cpuAddr), .cpuReady(cpuReady),
  .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memAck(memAck)
);

// ==== verif/test_ufc_cache.sv ====
// Self-checking bench for the unified four-way cache
`timescale 1ns/1ps
module test_ufc_cache;
  logic        sys_clk, avsWaitrequest, cpuReady, memReq, memWrite, memAck;
  logic        rstn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, cpuReq = 1'b0, cpuWrite = 1'b0;
  logic [1:0]  avsAddress = 2'h0;
  logic [31:0] avsWriteData = 32'h0, cpuAddr = 32'h0, cpuWdata = 32'h0;
  logic [31:0] avsReadData, cpuRdata, memAddr, memWdata, memRdata, q, old;
  logic [31:0] vis [logic [31:0]];
  integer      seed = 32'h2557;
  int          bad_count = 0, comparisons = 0, beats = 0, wbeats = 0;
  int          seqT [13] = '{0, 1, 2, 3, 0, 4, 0, 2, 3, 4, 1, 0, 2};
  int          seqB [13] = '{4, 4, 4, 4, 0, 4, 0, 0, 0, 0, 4, 4, 4};

  ufc_cache #(.ENTRIES(64)) u_ufc_cache (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest), .cpuReq(cpuReq),
    .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .cpuReady(cpuReady), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
  ufc_mem_model u_ufc_mem_model (
    .sys_clk(sys_clk), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Counts words moved on the external bus; hit or miss shows only here
  always @(posedge sys_clk) begin
    if (memReq === 1'b1 && memAck === 1'b1) begin
      beats++;
      if (memWrite === 1'b1) wbeats++;
    end
  end

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic tmo();
    bad_count++;
    $display("Error handshake expected done seen timeout");
    end_sim();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Value the core must see: last write, else the memory's initial pattern
  function automatic logic [31:0] rv(input logic [31:0] a);
    logic [31:0] k;
    k = {3'h0, a[28:0]};
    return vis.exists(k) ? vis[k] : k ^ 32'h5A5A0000;
  endfunction : rv
  task automatic avs(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= wr;
    avsRead      <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 100);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    if (n >= 100) tmo();
  endtask : avs
  task automatic rdc(input logic [1:0] a, input logic [31:0] e);
    avs(1'b0, a, 32'h0);
    chk("avsReadData", e, q);
  endtask : rdc
  // One core access; eb and ew are the expected bus words and write words
  task automatic acc(input logic wr, input logic [31:0] a, input int eb, input int ew);
    logic [31:0] d;
    int          b0, w0, n;
    d  = $random(seed);
    b0 = beats;
    w0 = wbeats;
    @(posedge sys_clk);
    cpuReq   <= 1'b1;
    cpuWrite <= wr;
    cpuAddr  <= a;
    cpuWdata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cpuReady !== 1'b1 && n < 300);
    cpuReq <= 1'b0;
    if (n >= 300) tmo();
    if (wr) vis[{3'h0, a[28:0]}] = d;
    else chk("cpuRdata", rv(a), cpuRdata);
    chk("memBeats", 32'(eb), 32'(beats - b0));
    chk("memWriteBeats", 32'(ew), 32'(wbeats - w0));
  endtask : acc

  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(2'h0, 32'h0);
    for (int i = 1; i < 4; i++) begin
      avs(1'b1, 2'(i), $random(seed));
      rdc(2'(i), 32'h0);
    end
    rdc(2'h0, 32'h0);
    acc(1'b0, 32'h100, 1, 0);
    acc(1'b1, 32'h100, 1, 1);
    acc(1'b0, 32'h100, 1, 0);
    avs(1'b1, 2'h0, 32'h1);
    rdc(2'h0, 32'h1);
    acc(1'b0, 32'h108, 4, 0);
    acc(1'b0, 32'h100, 0, 0);
    acc(1'b0, 32'h80000104, 0, 0);
    acc(1'b0, 32'hA0000100, 1, 0);
    acc(1'b0, 32'hA0000100, 1, 0);
    acc(1'b1, 32'hE0000010, 1, 1);
    // Five tags in one set: the least recently used one must go each time
    for (int i = 0; i < 13; i++) begin
      acc(1'b0, 32'h20 + 32'h400 * 32'(seqT[i]), seqB[i], 0);
    end
    acc(1'b0, 32'h100, 0, 0);
    acc(1'b1, 32'h40, 4, 0);
    for (int i = 1; i < 5; i++) begin
      acc(1'b0, 32'h40 + 32'h400 * 32'(i), (i == 4) ? 8 : 4, (i == 4) ? 4 : 0);
    end
    acc(1'b0, 32'h40, 4, 0);
    old = rv(32'h40);
    acc(1'b1, 32'h40, 0, 0);
    avs(1'b1, 2'h0, 32'h9);
    rdc(2'h0, 32'h1);
    vis[32'h40] = old;
    acc(1'b0, 32'h40, 4, 0);
    avs(1'b1, 2'h0, 32'h3);
    acc(1'b1, 32'h40, 1, 1);
    acc(1'b0, 32'h40, 0, 0);
    acc(1'b1, 32'hC0000044, 1, 1);
    acc(1'b0, 32'hC0000044, 0, 0);
    acc(1'b1, 32'h2000, 1, 1);
    acc(1'b0, 32'h2000, 4, 0);
    acc(1'b0, 32'h80000600, 4, 0);
    acc(1'b1, 32'h80000600, 1, 1);
    avs(1'b1, 2'h0, 32'h7);
    rdc(2'h0, 32'h7);
    acc(1'b1, 32'h80000600, 0, 0);
    acc(1'b0, 32'h80000600, 0, 0);
    end_sim();
  end
endmodule : test_ufc_cache
